// *** rtl/asc_pkg.sv ***
// Constants and types of the serial control block
package asc_pkg;
    // Register offsets (AHB-Lite bytes)
    localparam logic [7:0] ASC_OFF_CTRL_MODE  = 8'h00;
    localparam logic [7:0] ASC_OFF_STAT_EXT   = 8'h04;
    localparam logic [7:0] ASC_OFF_DATA       = 8'h08;
    localparam logic [7:0] ASC_OFF_BAUD       = 8'h0C;
    // Field positions in the control/mode word
    localparam int ASC_B_SOFT_CLEAR = 15;
    localparam int ASC_B_RX_INT_EN  = 12;
    localparam int ASC_B_TX_INT_EN  = 11;
    localparam int ASC_B_IDLE_INT   = 10;
    localparam int ASC_B_RX_EN      = 9;
    localparam int ASC_B_TX_EN      = 8;
    localparam int ASC_B_MODE_LO    = 5;
    localparam int ASC_B_STOP_LEN   = 3;
    localparam int ASC_B_BIT_ORDER  = 2;
    localparam int ASC_B_SER_OUT_EN = 0;
    // Field positions in the status/extended word
    localparam int ASC_B_RX_ERR_CLR = 15;
    localparam int ASC_B_PARITY_ERR = 13;
    localparam int ASC_B_FLIP       = 5;
    localparam int ASC_B_PAR_EN     = 4;
    localparam int ASC_B_PAR_ODD    = 3;
    // Reset values
    localparam logic [5:0]  ASC_FLAGS_CLEARED = 6'b00_0011;
    localparam logic [7:0]  ASC_CTRL_RESET    = 8'h00;
    localparam logic [7:0]  ASC_MODE_RESET    = 8'h00;
    localparam logic [14:0] ASC_BAUD_RESET    = 15'h0_004;
    // Mode codes
    localparam logic [2:0] ASC_MODE_NORMAL = 3'h0;
    localparam logic [2:0] ASC_MODE_MULTI  = 3'h1;
    localparam logic [2:0] ASC_MODE_SYNC   = 3'h2;
    localparam logic [2:0] ASC_MODE_LIN    = 3'h3;
    localparam logic [2:0] ASC_MODE_TWOW   = 3'h4;
    // Bit-time counter width
    localparam int ASC_BAUD_W = 15;
    typedef enum logic [1:0] {ASC_IDLE, ASC_START, ASC_BITS, ASC_STOP} asc_line_e;
endpackage

// *** rtl/asc_link_if.sv ***
// Serial link between the device end and the remote end
`timescale 1ns/1ps
interface asc_link_if;
    logic dev_txd;      // Device serial out, remote serial in
    logic rem_txd;      // Remote serial out, device serial in
    logic dev_rts_n;    // Device ready-to-receive, active low request
    modport device (output dev_txd, output dev_rts_n, input rem_txd);
    modport remote (input dev_txd, input dev_rts_n, output rem_txd);
endinterface

// *** rtl/asc_device.sv ***
// Device end: registers, mode logic and serial engine
// Behaviour
// R1: Mode field picks normal or multiprocessor
// R2: Ninth flag: 1 address, 0 data
// R3: Multiprocessor: no parity, flag every frame
// R4: Software uses word access for data
// R5: Soft clear aborts transfer, keeps settings
// R6: Soft clear reloads and restarts baud counter
// R7: Soft clear sets flags to 000011
// R8: Soft clear drives request-to-send low
// R9: Receive irq: enable and any rx flag
// R10: Transmit irq: enable and tx empty
// R11: Idle irq: enable and line idle
// R12: Start edge falling, rising when flipped
// R13: Rx enable cleared aborts reception
// R14: Reception disabled holds request-to-send low
// R15: Tx enable cleared aborts transmission
// R16: Mode change: soft clear, then new mode
// R17: Disable interrupts before soft clear
// R18: Reserved mode bit reads zero
// R19: Unused control bits ignore writes
// R20: Serial output enable gates data output
// R21: Bit order: 0 LSB, 1 MSB first
`timescale 1ns/1ps
module asc_device
    import asc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [7:0]  haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Interrupt requests
    output logic             rx_irq_out,
    output logic             tx_irq_out,
    output logic             idle_irq_out,
    // Serial link
    asc_link_if.device       link
);
    typedef struct packed {
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [15:0] ctrl;      // control[15:8], mode[7:0]
        logic [7:0]  ext;       // extended control
        logic [14:0] reload;
        logic [14:0] tx_cnt;
        logic [14:0] rx_cnt;
        logic [5:0]  flags;     // parity, framing, overrun, rx_full, tx_empty, idle
        logic [8:0]  tx_hold;
        logic [8:0]  rx_data;
        asc_line_e   tx_st;
        asc_line_e   rx_st;
        logic [10:0] tx_sh;
        logic [3:0]  tx_n;
        logic [8:0]  rx_sh;
        logic [3:0]  rx_n;
        logic        rx_prev;
        logic        txd;
    } asc_dev_s;

    asc_dev_s st_r, st_nxt;

    // Frame length of payload plus flag bit
    function automatic logic [3:0] asc_bits(input logic multi);
        asc_bits = multi ? 4'h9 : 4'h8;
    endfunction

    logic        multi;
    logic        flip;
    logic        par_on;
    logic        rxd;
    logic        bit_tick_tx;
    logic        bit_tick_rx;
    logic        rd_data;
    logic [31:0] rd_word;
    logic        take;

    // Mode decoding, multiprocessor forces parity off
    assign multi  = (st_r.ctrl[ASC_B_MODE_LO+:3] == ASC_MODE_MULTI); // [R1]
    assign par_on = st_r.ext[ASC_B_PAR_EN] && !multi;                // [R3]
    assign flip   = st_r.ext[ASC_B_FLIP];
    assign rxd    = link.rem_txd ^ flip;
    assign bit_tick_tx = (st_r.tx_cnt == '0);
    assign bit_tick_rx = (st_r.rx_cnt == '0);
    assign take   = hsel_in && hready_in && htrans_in[1];
    assign rd_data = take && !hwrite_in && (haddr_in == ASC_OFF_DATA);

    // Read mux; unused control bits and reserved mode bits read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (haddr_in)
            ASC_OFF_CTRL_MODE: rd_word = {16'h0000, 1'b0, 2'b00, st_r.ctrl[12:5], 1'b0,
                                          st_r.ctrl[3:2], 1'b0, st_r.ctrl[0]}; // [R18] [R19]
            ASC_OFF_STAT_EXT:  rd_word = {16'h0000, 2'b00, st_r.flags, st_r.ext};
            ASC_OFF_DATA:      rd_word = {23'h00_0000, st_r.rx_data};
            ASC_OFF_BAUD:      rd_word = {17'h0_0000, st_r.reload};
            default:           rd_word = 32'h0000_0000;
        endcase
    end

    // Next state of registers, flags and engines
    always_comb
    begin
        logic       clr;
        logic [8:0] wv;
        logic       wr_now;
        logic [3:0] nb;
        clr    = 1'b0;
        wv     = '0;
        wr_now = st_r.wr_pend;
        nb     = asc_bits(multi);
        st_nxt = st_r;
        st_nxt.wr_pend = take && hwrite_in;
        st_nxt.wr_addr = haddr_in;
        st_nxt.rx_prev = rxd;
        st_nxt.tx_cnt  = bit_tick_tx ? st_r.reload : st_r.tx_cnt - 15'h0001;
        st_nxt.rx_cnt  = bit_tick_rx ? st_r.reload : st_r.rx_cnt - 15'h0001;
        // Reading data empties the receive holding register
        if (rd_data)
            st_nxt.flags[2] = 1'b0;
        // Register writes; control bits 14:13 are dropped
        if (wr_now)
        begin
            unique case (st_r.wr_addr)
                ASC_OFF_CTRL_MODE:
                begin
                    st_nxt.ctrl = {1'b0, 2'b00, hwdata_in[12:5], 1'b0,
                                   hwdata_in[3:2], 1'b0, hwdata_in[0]}; // [R19] [R18]
                    clr = hwdata_in[ASC_B_SOFT_CLEAR];                  // [R5]
                end
                ASC_OFF_STAT_EXT:
                begin
                    st_nxt.ext = hwdata_in[7:0];
                    if (hwdata_in[ASC_B_RX_ERR_CLR])
                        st_nxt.flags[5:3] = 3'b000;
                end
                ASC_OFF_DATA:
                begin
                    // Whole word carries the address/data flag
                    wv = multi ? hwdata_in[8:0] : {1'b0, hwdata_in[7:0]}; // [R4] [R2]
                    st_nxt.tx_hold = wv;
                    st_nxt.flags[1:0] = 2'b00;
                end
                ASC_OFF_BAUD:
                begin
                    st_nxt.reload = hwdata_in[14:0];
                    st_nxt.tx_cnt = hwdata_in[14:0];
                    st_nxt.rx_cnt = hwdata_in[14:0];
                end
                default: ;
            endcase
        end
        // Transmit engine
        unique case (st_r.tx_st)
            ASC_IDLE:
            begin
                st_nxt.txd = 1'b1;
                if (st_r.ctrl[ASC_B_TX_EN] && !st_r.flags[1] && !wr_now && bit_tick_tx)
                begin
                    // Order select reverses payload before shifting
                    for (int i = 0; i < 9; i++)
                        st_nxt.tx_sh[i] = st_r.ctrl[ASC_B_BIT_ORDER] ?
                            st_r.tx_hold[(nb - 4'h1 - 4'(i)) % 9] : st_r.tx_hold[i]; // [R21]
                    if (!multi)
                        st_nxt.tx_sh[8] = par_on ? (^st_r.tx_hold[7:0]
                                          ^ st_r.ext[ASC_B_PAR_ODD]) : 1'b1;
                    st_nxt.tx_sh[10:9] = 2'b11;
                    st_nxt.tx_n  = nb + (par_on ? 4'h1 : 4'h0) + 4'h1
                                   + (st_r.ctrl[ASC_B_STOP_LEN] ? 4'h1 : 4'h0); // [R3]
                    st_nxt.txd   = 1'b0;
                    st_nxt.flags[1] = 1'b1;
                    st_nxt.tx_st = ASC_BITS;
                end
                else if (st_nxt.flags[1])
                    st_nxt.flags[0] = 1'b1; // Data write keeps idle low [R11]
            end
            ASC_BITS:
                if (bit_tick_tx)
                begin
                    st_nxt.txd   = st_r.tx_sh[0];
                    st_nxt.tx_sh = {1'b1, st_r.tx_sh[10:1]};
                    st_nxt.tx_n  = st_r.tx_n - 4'h1;
                    if (st_r.tx_n == 4'h0)
                    begin
                        st_nxt.txd   = 1'b1;
                        st_nxt.tx_st = ASC_IDLE;
                    end
                end
            default: st_nxt.tx_st = ASC_IDLE;
        endcase
        if (!st_r.ctrl[ASC_B_TX_EN] && st_r.tx_st != ASC_IDLE)
        begin
            st_nxt.tx_st = ASC_IDLE;    // [R15]
            st_nxt.txd   = 1'b1;
        end
        // Receive engine
        unique case (st_r.rx_st)
            ASC_IDLE:
                // Line already decoded for polarity, so a fall is a start edge
                if (st_r.ctrl[ASC_B_RX_EN] && st_r.rx_prev && !rxd)
                begin
                    st_nxt.rx_cnt = {1'b0, st_r.reload[14:1]}; // Sample mid-bit
                    st_nxt.rx_st  = ASC_START;                   // [R12]
                end
            ASC_START:
                if (bit_tick_rx)
                begin
                    st_nxt.rx_st = rxd ? ASC_IDLE : ASC_BITS;
                    st_nxt.rx_n  = nb + (par_on ? 4'h1 : 4'h0);
                    st_nxt.rx_sh = '0;
                end
            ASC_BITS:
                if (bit_tick_rx)
                begin
                    st_nxt.rx_sh = {rxd, st_r.rx_sh[8:1]};
                    st_nxt.rx_n  = st_r.rx_n - 4'h1;
                    if (st_r.rx_n == 4'h1)
                        st_nxt.rx_st = ASC_STOP;
                end
            ASC_STOP:
                if (bit_tick_rx)
                begin
                    st_nxt.rx_st = ASC_IDLE;
                    wv = multi ? st_r.rx_sh : (par_on ? {1'b0, st_r.rx_sh[7:0]}
                                                      : {1'b0, st_r.rx_sh[8:1]});
                    if (st_r.ctrl[ASC_B_BIT_ORDER])
                        for (int i = 0; i < 9; i++)
                            st_nxt.rx_data[i] = (4'(i) < nb) ? wv[nb - 4'h1 - 4'(i)] : 1'b0;
                    else
                        st_nxt.rx_data = wv;                 // [R21] [R2]
                    if (par_on && (^st_r.rx_sh ^ st_r.ext[ASC_B_PAR_ODD]))
                        st_nxt.flags[5] = 1'b1;
                    if (!rxd)
                        st_nxt.flags[4] = 1'b1;
                    if (st_r.flags[2] && !rd_data)
                        st_nxt.flags[3] = 1'b1;
                    st_nxt.flags[2] = 1'b1;                  // Set wins over read
                end
            default: st_nxt.rx_st = ASC_IDLE;
        endcase
        if (!st_r.ctrl[ASC_B_RX_EN] && st_r.rx_st != ASC_IDLE)
            st_nxt.rx_st = ASC_IDLE;                         // [R13]
        // Soft clear: abort, reload counters, fixed flag pattern, keep settings
        if (clr)
        begin
            st_nxt.tx_st  = ASC_IDLE;                        // [R5]
            st_nxt.rx_st  = ASC_IDLE;
            st_nxt.txd    = 1'b1;
            st_nxt.tx_cnt = st_r.reload;                     // [R6]
            st_nxt.rx_cnt = st_r.reload;
            st_nxt.flags  = ASC_FLAGS_CLEARED;               // [R7]
        end
    end

    // State register
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            st_r        <= '0;
            st_r.ctrl   <= {ASC_CTRL_RESET, ASC_MODE_RESET};
            st_r.reload <= ASC_BAUD_RESET;
            st_r.flags  <= ASC_FLAGS_CLEARED;
            st_r.rx_prev <= 1'b1;
            st_r.txd    <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // Bus answers and read data; reads are zero-wait
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            hrdata_out <= 32'h0000_0000;
        else if (take && !hwrite_in)
            hrdata_out <= rd_word;
    end
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    // Interrupt requests gated by their enables
    assign rx_irq_out   = st_r.ctrl[ASC_B_RX_INT_EN] && (|st_r.flags[5:2]); // [R9]
    assign tx_irq_out   = st_r.ctrl[ASC_B_TX_INT_EN] && st_r.flags[1];      // [R10]
    assign idle_irq_out = st_r.ctrl[ASC_B_IDLE_INT] && st_r.flags[0];       // [R11]

    // Line outputs; no flow control, so request stays low
    assign link.dev_txd   = (st_r.ctrl[ASC_B_SER_OUT_EN] ? st_r.txd : 1'b1) ^ flip; // [R20]
    assign link.dev_rts_n = 1'b0; // [R14] [R8]
endmodule

// *** rtl/asc_remote.sv ***
// Remote end: 8N1 or 9-bit multiprocessor UART
`timescale 1ns/1ps
module asc_remote
    import asc_pkg::*;
#(
    parameter logic [ASC_BAUD_W-1:0] RELOAD = ASC_BAUD_RESET
)
(
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    // User side
    input  wire logic       multi_in,     // Send and expect the ninth flag
    input  wire logic       send_in,
    input  wire logic [8:0] send_data_in, // Bit 8 is the address/data flag
    output logic            busy_out,
    output logic            rx_valid_out,
    output logic      [8:0] rx_data_out,
    // Serial link
    asc_link_if.remote      link
);
    typedef struct packed {
        logic [14:0] tcnt;
        logic [14:0] rcnt;
        logic [10:0] tsh;
        logic [3:0]  tn;
        logic        tbusy;
        logic        txd;
        asc_line_e   rst;
        logic [8:0]  rsh;
        logic [3:0]  rn;
        logic        rprev;
        logic        rvalid;
        logic [8:0]  rdata;
    } asc_rem_s;

    asc_rem_s s_r, s_nxt;
    logic [3:0] nb;

    // Payload plus flag bit in multiprocessor mode
    assign nb = multi_in ? 4'h9 : 4'h8;

    // Transmit and receive, LSB first, one stop bit
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;
        s_nxt.rprev  = link.dev_txd;
        s_nxt.tcnt   = (s_r.tcnt == '0) ? RELOAD : s_r.tcnt - 15'h0001;
        s_nxt.rcnt   = (s_r.rcnt == '0) ? RELOAD : s_r.rcnt - 15'h0001;
        if (!s_r.tbusy && send_in)
        begin
            s_nxt.tsh   = {2'b11, multi_in ? send_data_in : {1'b1, send_data_in[7:0]}}; // [R2]
            s_nxt.tn    = nb + 4'h1;
            s_nxt.tbusy = 1'b1;
            s_nxt.txd   = 1'b0;
            s_nxt.tcnt  = RELOAD;
        end
        else if (s_r.tbusy && s_r.tcnt == '0)
        begin
            s_nxt.txd = s_r.tsh[0];
            s_nxt.tsh = {1'b1, s_r.tsh[10:1]};
            s_nxt.tn  = s_r.tn - 4'h1;
            if (s_r.tn == 4'h0)
                s_nxt.tbusy = 1'b0;
        end
        unique case (s_r.rst)
            ASC_IDLE:
                if (s_r.rprev && !link.dev_txd)
                begin
                    s_nxt.rcnt = {1'b0, RELOAD[14:1]};
                    s_nxt.rst  = ASC_START;
                end
            ASC_START:
                if (s_r.rcnt == '0)
                begin
                    s_nxt.rst = link.dev_txd ? ASC_IDLE : ASC_BITS;
                    s_nxt.rn  = nb;
                    s_nxt.rsh = '0;
                end
            ASC_BITS:
                if (s_r.rcnt == '0)
                begin
                    s_nxt.rsh = {link.dev_txd, s_r.rsh[8:1]};
                    s_nxt.rn  = s_r.rn - 4'h1;
                    if (s_r.rn == 4'h1)
                        s_nxt.rst = ASC_STOP;
                end
            ASC_STOP:
                if (s_r.rcnt == '0)
                begin
                    s_nxt.rst    = ASC_IDLE;
                    s_nxt.rvalid = 1'b1;
                    s_nxt.rdata  = multi_in ? s_r.rsh : {1'b0, s_r.rsh[8:1]};
                end
            default: s_nxt.rst = ASC_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            s_r       <= '0;
            s_r.txd   <= 1'b1;
            s_r.rprev <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign link.rem_txd = s_r.txd;
    assign busy_out     = s_r.tbusy;
    assign rx_valid_out = s_r.rvalid;
    assign rx_data_out  = s_r.rdata;
endmodule

// *** tb/asc_link_chk.sv ***
// Concurrent checks on the serial link
`timescale 1ns/1ps
module asc_link_chk
#(
    parameter int BIT_CLKS = 5
)
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Link lines
    input wire logic dev_txd,
    input wire logic rem_txd,
    input wire logic dev_rts_n
);
    localparam int FRAME_MAX = 12 * BIT_CLKS;
    logic        dtx_q;
    logic        rtx_q;
    logic [15:0] dev_cnt;
    logic [15:0] rem_cnt;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // Run length of each line level; saturates so long idles never wrap
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            dtx_q   <= 1'b1;
            rtx_q   <= 1'b1;
            dev_cnt <= 16'h0000;
            rem_cnt <= 16'h0000;
        end
        else
        begin
            dtx_q   <= dev_txd;
            rtx_q   <= rem_txd;
            dev_cnt <= (dev_txd != dtx_q) ? 16'h0001 : dev_cnt + 16'(dev_cnt != 16'hFFFF);
            rem_cnt <= (rem_txd != rtx_q) ? 16'h0001 : rem_cnt + 16'(rem_cnt != 16'hFFFF);
        end
    end

    // Frame opens on a fall, closes on a whole high bit
    sequence dev_start;
        dtx_q && !dev_txd;
    endsequence
    sequence dev_stop;
        dtx_q && dev_cnt >= BIT_CLKS;
    endsequence
    sequence rem_start;
        rtx_q && !rem_txd;
    endsequence
    sequence rem_stop;
        rtx_q && rem_cnt >= BIT_CLKS;
    endsequence

    a_rts_held_low: assert property (!dev_rts_n)
        else $error("rts high");
    a_dev_idle_reset: assert property ($fell(rst_in) |-> dev_txd [*8])
        else $error("dev txd low after reset");
    a_rem_idle_reset: assert property ($fell(rst_in) |-> rem_txd [*8])
        else $error("rem txd low after reset");
    a_dev_fall_spacing: assert property (dev_start |-> dev_cnt >= BIT_CLKS)
        else $error("dev short high before start");
    a_rem_fall_spacing: assert property (rem_start |-> rem_cnt >= BIT_CLKS)
        else $error("rem short high before start");
    a_rem_low_run: assert property ((!rtx_q && rem_txd) |->
        (rem_cnt % BIT_CLKS == 0) && (rem_cnt <= 10 * BIT_CLKS))
        else $error("rem low off grid");
    a_rem_frame_end: assert property (rem_start |-> ##[1:FRAME_MAX] rem_stop)
        else $error("rem frame open");
    a_dev_frame_end: assert property (dev_start |-> ##[1:FRAME_MAX] dev_stop)
        else $error("dev frame open");
endmodule

// *** tb/async_serial_control_tb.sv ***
// Bench for the device and remote ends
`timescale 1ns/1ps
module async_serial_control_tb;
    import asc_pkg::*;
    localparam logic [ASC_BAUD_W-1:0] RELOAD = 15'h0004;
    localparam int BITS = int'(RELOAD) + 1;
    localparam logic [31:0] EN = 32'h0000_0301;
    localparam logic [31:0] ST0 = {18'h0_0000, ASC_FLAGS_CLEARED, 8'h00};
    // Bus and remote user side
    logic        sys_clk_in = 1'b0;
    logic        rst_in     = 1'b1;
    logic        hsel       = 1'b0;
    logic [7:0]  haddr      = 8'h00;
    logic [1:0]  htrans     = 2'h0;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        rx_irq;
    logic        tx_irq;
    logic        idle_irq;
    logic        multi      = 1'b0;
    logic        send       = 1'b0;
    logic [8:0]  send_data;
    logic        busy;
    logic        rx_valid;
    logic [8:0]  rx_data;
    logic [8:0]  rx_last;
    int          rx_cnt      = 0;
    int          miscompares = 0;
    int          n_checks    = 0;
    int          cycles      = 0;

    asc_link_if link ();

    // Free-running bus clock
    always #25 sys_clk_in = ~sys_clk_in;

    asc_device u_asc_device (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
        .hreadyout_out(hreadyout), .hresp_out(), .rx_irq_out(rx_irq),
        .tx_irq_out(tx_irq), .idle_irq_out(idle_irq), .link(link));
    asc_remote #(.RELOAD(RELOAD)) u_asc_remote (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .multi_in(multi), .send_in(send), .send_data_in(send_data), .busy_out(busy),
        .rx_valid_out(rx_valid), .rx_data_out(rx_data), .link(link));
    asc_link_chk #(.BIT_CLKS(BITS)) u_asc_link_chk (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .dev_txd(link.dev_txd), .rem_txd(link.rem_txd),
        .dev_rts_n(link.dev_rts_n));

    // Remote deliveries and the hang watchdog
    always @(posedge sys_clk_in)
    begin
        cycles <= cycles + 1;
        if (rx_valid === 1'b1)
        begin
            rx_last <= rx_data;
            rx_cnt  <= rx_cnt + 1;
        end
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            results();
        end
    end

    task automatic results();
        if (miscompares == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One AHB-Lite word transfer, paced by hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge sys_clk_in); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk(what, exp, x);
    endtask

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
    endfunction

    task automatic rem_send(input logic [8:0] d);
        while (busy !== 1'b0) @(posedge sys_clk_in);
        send      <= 1'b1;
        send_data <= d;
        @(posedge sys_clk_in);
        send <= 1'b0;
    endtask

    // Remote frame in, poll rx full, read
    task automatic rem_to_dev(input logic [8:0] d, input logic [8:0] exp);
        logic [31:0] s;
        s = 32'h0000_0000;
        rem_send(d);
        while (s[10] !== 1'b1) bus(1'b0, ASC_OFF_STAT_EXT, 32'h0000_0000, s);
        rdchk("device_rx", ASC_OFF_DATA, {23'h0, exp});
    endtask

    task automatic dev_to_rem(input logic [8:0] d, input logic [8:0] exp);
        int n;
        n = rx_cnt;
        wr(ASC_OFF_DATA, {23'h0, d});
        while (rx_cnt == n) @(posedge sys_clk_in);
        chk("remote_rx", {23'h0, exp}, {23'h0, rx_last});
    endtask

    // Lows on the device line over a frame
    task automatic quiet_line(input string what);
        int lows;
        lows = 0;
        repeat (2) @(posedge sys_clk_in);
        repeat (12 * BITS) @(posedge sys_clk_in) if (link.dev_txd !== 1'b1) lows++;
        chk(what, 32'h0000_0000, lows);
    endtask

    // A zero byte keeps the line low, so a late abort is visible
    task automatic abort_tx(input logic [31:0] ctl);
        wr(ASC_OFF_CTRL_MODE, EN);
        wr(ASC_OFF_DATA, 32'h0000_0000);
        while (link.dev_txd !== 1'b0) @(posedge sys_clk_in);
        repeat (2 * BITS) @(posedge sys_clk_in);
        wr(ASC_OFF_CTRL_MODE, ctl);
        quiet_line("txd_after_abort");
    endtask

    initial
    begin
        logic [31:0] w;
        logic [7:0]  b;
        void'($urandom(69));
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rdchk("ctrl_mode", ASC_OFF_CTRL_MODE, 32'h0000_0000);
        rdchk("status", ASC_OFF_STAT_EXT, ST0);
        rdchk("reload", ASC_OFF_BAUD, {17'h0_0000, ASC_BAUD_RESET});
        // Random control words, legal modes only
        repeat (8)
        begin
            w = $urandom & 32'h0000_7FED;
            w[7:6] = 2'h0;
            wr(ASC_OFF_CTRL_MODE, w);
            rdchk("ctrl_mode", ASC_OFF_CTRL_MODE, w & 32'h0000_1FED);
            chk("irqs", {30'h0, w[11:10]}, {29'h0, rx_irq, tx_irq, idle_irq});
        end
        wr(8'h10, 32'hFFFF_FFFF);
        rdchk("unmapped", 8'h10, 32'h0000_0000);
        rdchk("ctrl_kept", ASC_OFF_CTRL_MODE, w & 32'h0000_1FED);
        w = $urandom & 32'h0000_80DF;
        wr(ASC_OFF_STAT_EXT, w);
        rdchk("ext", ASC_OFF_STAT_EXT, {18'h0_0000, ASC_FLAGS_CLEARED, w[7:0]});
        wr(ASC_OFF_STAT_EXT, 32'h0000_0000);
        wr(ASC_OFF_BAUD, {17'h0_0000, RELOAD});
        // Normal mode both ways, corner bytes first
        wr(ASC_OFF_CTRL_MODE, EN);
        for (int i = 0; i < 6; i++)
        begin
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            rem_to_dev({1'b0, b}, {1'b0, b});
            dev_to_rem({1'b0, b}, {1'b0, b});
        end
        wr(ASC_OFF_CTRL_MODE, EN | 32'h0000_1000);
        rem_send(9'h05A);
        while (rx_irq !== 1'b1) @(posedge sys_clk_in);
        chk("rx_irq", 32'h0000_0001, {31'h0, rx_irq});
        rdchk("rx_data", ASC_OFF_DATA, 32'h0000_005A);
        @(posedge sys_clk_in);
        chk("rx_irq", 32'h0000_0000, {31'h0, rx_irq});
        // MSB first: remote sees it mirrored
        wr(ASC_OFF_CTRL_MODE, EN | 32'h0000_0004);
        b = 8'h80 | (8'($urandom) & 8'h7E);
        dev_to_rem({1'b0, b}, {1'b0, rev8(b)});
        rem_to_dev({1'b0, b}, {1'b0, rev8(b)});
        // Mode change: clear, then new mode
        wr(ASC_OFF_CTRL_MODE, EN | 32'h0000_8000);
        wr(ASC_OFF_CTRL_MODE, EN | 32'h0000_0028);
        multi <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            b = 8'($urandom);
            rem_to_dev({i[0], b}, {i[0], b});
            dev_to_rem({!i[0], b}, {!i[0], b});
        end
        wr(ASC_OFF_CTRL_MODE, EN | 32'h0000_8028);
        wr(ASC_OFF_CTRL_MODE, EN);
        multi <= 1'b0;
        // Mid-frame aborts idle the line, or drop the frame being received
        abort_tx(EN | 32'h0000_8000);
        rdchk("status", ASC_OFF_STAT_EXT, ST0);
        rdchk("ctrl_kept", ASC_OFF_CTRL_MODE, EN);
        abort_tx(EN & 32'h0000_FEFF);
        wr(ASC_OFF_CTRL_MODE, EN | 32'h0000_8000);
        rem_send(9'h000);
        while (link.rem_txd !== 1'b0) @(posedge sys_clk_in);
        repeat (2 * BITS) @(posedge sys_clk_in);
        wr(ASC_OFF_CTRL_MODE, EN & 32'h0000_FDFF);
        repeat (12 * BITS) @(posedge sys_clk_in);
        wr(ASC_OFF_CTRL_MODE, EN);
        rdchk("status", ASC_OFF_STAT_EXT, ST0);
        // Output off: queued frame stays off the wire
        wr(ASC_OFF_CTRL_MODE, EN & 32'h0000_FFFE);
        wr(ASC_OFF_DATA, 32'h0000_0000);
        quiet_line("txd_gated");
        results();
    end
endmodule
